// [logic/lbx_pkg.sv]
// package: encodings, field positions and types for the logic/bit-op execute block
`default_nettype none
package lbx_pkg;
   localparam logic [11:0] LBX_AND_MASK = 12'hFC0;
   localparam logic [11:0] LBX_AND_PAT = 12'h140;
   localparam logic [11:0] LBX_BIT_MASK = 12'hF00;
   localparam logic [11:0] LBX_BCLR_PAT = 12'h400;
   localparam logic [11:0] LBX_BSET_PAT = 12'h500;
   localparam logic [11:0] LBX_BTSC_PAT = 12'h600;
   localparam logic [11:0] LBX_NOP = 12'h000;
   localparam int LBX_DEST_BIT = 5;
   localparam int LBX_BIDX_LSB = 5;
   localparam int LBX_BIDX_W = 3;
   localparam int LBX_ADDR_W = 5;
   localparam logic [4:0] LBX_TIMER_ADDR = 5'h01;
   localparam logic [7:0] LBX_ACC_RST = 8'h00;

   typedef enum logic [1:0] {
      LBX_OP_NONE = 2'h0,
      LBX_OP_AND = 2'h1,
      LBX_OP_BIT = 2'h3,
      LBX_OP_TEST = 2'h2
   } lbx_op_t;

   // register file write request
   typedef struct packed {
      logic en;
      logic [4:0] addr;
      logic [7:0] data;
   } lbx_wr_t;
endpackage
`default_nettype wire

// [logic/lbx_decode.sv]
// instruction field decoder for the logic/bit-op execute block
`default_nettype none
module lbx_decode import lbx_pkg::*; (
   // instruction word
   input wire logic [11:0] instr,
   // decoded fields
   output lbx_op_t op,
   output logic set_bit,
   output logic dest_reg,
   output logic [4:0] addr,
   output logic [7:0] bit_mask
);
   wire is_and = (instr & LBX_AND_MASK) == LBX_AND_PAT;
   wire is_bclr = (instr & LBX_BIT_MASK) == LBX_BCLR_PAT;
   wire is_bset = (instr & LBX_BIT_MASK) == LBX_BSET_PAT;
   wire is_btsc = (instr & LBX_BIT_MASK) == LBX_BTSC_PAT;
   wire [2:0] bidx = instr[LBX_BIDX_LSB +: LBX_BIDX_W];

   // field extraction: 5-bit address, 3-bit bit index
   assign addr = instr[LBX_ADDR_W-1:0];
   assign bit_mask = 8'h01 << bidx;
   assign dest_reg = instr[LBX_DEST_BIT];
   assign set_bit = is_bset;
   assign op = is_and ? LBX_OP_AND : (is_bclr | is_bset) ? LBX_OP_BIT :
               is_btsc ? LBX_OP_TEST : LBX_OP_NONE;
endmodule
`default_nettype wire

// [logic/lbx_exec.sv]
// execute stage for AND-with-register and bit clear/set/test-skip instructions
// Functional notes
// - AND accumulator with addressed register; only the zero flag changes.
// - Destination bit zero: result goes to accumulator, register untouched.
// - Destination bit one: result written back to the addressed register.
// - Bit ops use 5-bit register address and 3-bit bit index.
// - Test-skip-if-clear with bit zero discards prefetched instruction, runs a no-op.
// - Test-skip takes one cycle without skip, two with skip.
// - Port registers read live pin levels as the modify source.
// - Write-back to the timer register clears the prescaler when assigned.
`default_nettype none
module lbx_exec import lbx_pkg::*; (
   // clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // instruction from fetch; valid when instr_valid
   input wire logic [11:0] instr,
   input wire logic instr_valid,
   // register file read port
   output logic [4:0] rd_addr,
   input wire logic [7:0] rd_data,
   // live pin levels and port address flag
   input wire logic rd_is_port,
   input wire logic [7:0] pin_data,
   // prescaler assignment
   input wire logic psa_timer,
   // results
   output lbx_wr_t reg_wr,
   output logic [7:0] acc,
   output logic zero_flag,
   output logic zero_we,
   output logic flush,
   output logic prescaler_clr
);
   typedef enum logic [0:0] {LBX_RUN = 1'b0, LBX_SKIP = 1'b1} lbx_st_t;

   // decoded fields of the word in the execute slot
   lbx_op_t op;
   logic set_bit, dest_reg;
   logic [4:0] addr;
   logic [7:0] bit_mask;
   // state and result registers with their next values
   lbx_st_t st_r, st_nxt;
   logic [7:0] acc_r, acc_nxt;
   logic z_r, z_nxt, zwe_r, zwe_nxt;
   lbx_wr_t wr_r, wr_nxt;
   logic psc_r, psc_nxt;

   lbx_decode u_dec (
      .instr(instr),
      .op(op),
      .set_bit(set_bit),
      .dest_reg(dest_reg),
      .addr(addr),
      .bit_mask(bit_mask)
   );

   // the register file answers in the same cycle; a registered read port would
   // need one more stage here and would break the one-cycle timing of every op
   // operand selection and computed results
   wire [7:0] src = rd_is_port ? pin_data : rd_data;
   wire [7:0] and_res = acc_r & src;
   wire [7:0] bit_res = set_bit ? (src | bit_mask) : (src & ~bit_mask);
   wire bit_clear = (src & bit_mask) == 8'h00;
   wire run = instr_valid && st_r == LBX_RUN;
   wire do_and = run && op == LBX_OP_AND;
   wire do_bit = run && op == LBX_OP_BIT;
   wire take_skip = run && op == LBX_OP_TEST && bit_clear;
   wire and_to_reg = do_and && dest_reg;
   wire reg_write = and_to_reg || do_bit;

   assign rd_addr = addr;
   // gated by the enable so a frozen core never drops a fetched word
   assign flush = take_skip && ce;

   // next-state and result selection
   always_comb begin
      st_nxt = LBX_RUN;
      case (st_r)
         LBX_RUN: st_nxt = take_skip ? LBX_SKIP : LBX_RUN;
         LBX_SKIP: st_nxt = LBX_RUN;
         default: st_nxt = LBX_RUN;
      endcase
      acc_nxt = (do_and && !dest_reg) ? and_res : acc_r;
      z_nxt = do_and ? (and_res == 8'h00) : z_r;
      zwe_nxt = do_and;
      wr_nxt.en = reg_write;
      wr_nxt.addr = addr;
      wr_nxt.data = do_bit ? bit_res : and_res;
      psc_nxt = reg_write && addr == LBX_TIMER_ADDR && psa_timer;
   end

   // state registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= LBX_RUN;
         acc_r <= LBX_ACC_RST;
         z_r <= 1'b0;
         zwe_r <= 1'b0;
         wr_r <= '0;
         psc_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         acc_r <= acc_nxt;
         z_r <= z_nxt;
         zwe_r <= zwe_nxt;
         wr_r <= wr_nxt;
         psc_r <= psc_nxt;
      end
   end

   assign acc = acc_r;
   assign zero_flag = z_r;
   assign zero_we = zwe_r;
   assign reg_wr = wr_r;
   assign prescaler_clr = psc_r;

   // checks
   sequence skip_start_s;
      ce && take_skip;
   endsequence
   and_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_and |=> zero_we && zero_flag == (($past(acc_r) & $past(src)) == 8'h00))
      else $error("zero flag wrong after and");
   acc_dest_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_and && !dest_reg |=> !reg_wr.en && acc == $past(and_res))
      else $error("acc destination wrong");
   reg_dest_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_and && dest_reg |=> reg_wr.en && acc == $past(acc_r))
      else $error("reg destination wrong");
   bit_addr_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_bit |=> reg_wr.addr == $past(instr[4:0]))
      else $error("bit op address wrong");
   skip_flush_a: assert property (@(posedge clk) disable iff (!resetn)
      skip_start_s |-> flush ##1 (st_r == LBX_SKIP))
      else $error("skip not taken");
   skip_len_a: assert property (@(posedge clk) disable iff (!resetn)
      skip_start_s ##1 ce |=> st_r == LBX_RUN)
      else $error("skip not two cycles");
   bit_force_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_bit |=> !zero_we && ((reg_wr.data & $past(bit_mask)) != 8'h00)
         == $past(set_bit))
      else $error("bit force wrong");
   port_src_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_bit && rd_is_port |=> (reg_wr.data & ~$past(bit_mask))
         == ($past(pin_data) & ~$past(bit_mask)))
      else $error("port source not pins");
   psc_clr_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && reg_write && addr == LBX_TIMER_ADDR && psa_timer |=> prescaler_clr)
      else $error("prescaler not cleared");

   // the skip slot makes no write, no flag pulse and no prescaler clear
   sequence skip_slot_s;
      ce && st_r == LBX_SKIP;
   endsequence
   skip_slot_a: assert property (@(posedge clk) disable iff (!resetn)
      skip_slot_s |-> !flush ##1 (!reg_wr.en && !zero_we && !prescaler_clr))
      else $error("skip slot not discarded");

   // a frozen core must not ask fetch to discard anything
   flush_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      !ce |-> !flush)
      else $error("flush while frozen");

   // a test that finds its bit set runs in one cycle with no discard
   sequence test_set_s;
      ce && run && op == LBX_OP_TEST && !bit_clear;
   endsequence
   no_skip_a: assert property (@(posedge clk) disable iff (!resetn)
      test_set_s |-> !flush ##1 (st_r == LBX_RUN && !reg_wr.en && !zero_we))
      else $error("test with bit set skipped");

   // an AND written back carries its result to the addressed register
   and_wdata_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && and_to_reg |=> reg_wr.data == $past(and_res)
         && reg_wr.addr == $past(addr))
      else $error("and write-back wrong");

   // the accumulator only changes on an AND aimed at it
   acc_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && !(do_and && !dest_reg) |=> acc == $past(acc_r))
      else $error("acc changed without and");

   // only the AND touches the zero flag
   zero_only_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && !do_and |=> !zero_we && zero_flag == $past(z_r))
      else $error("zero flag touched by other op");

   // bit ops leave the zero flag alone
   bit_flags_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_bit |=> zero_flag == $past(z_r))
      else $error("bit op changed zero flag");

   // bit ops from memory keep every other bit of the register
   bit_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_bit && !rd_is_port |=> (reg_wr.data & ~$past(bit_mask))
         == ($past(rd_data) & ~$past(bit_mask)))
      else $error("bit op disturbed other bits");

   // the bit mask follows the three-bit index field of the word
   bit_idx_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && do_bit |=> $past(bit_mask) == (8'h01 << $past(instr[7:5])))
      else $error("bit index wrong");

   // no timer write, or prescaler not with the timer: no clear
   psc_idle_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && !(reg_write && addr == LBX_TIMER_ADDR && psa_timer) |=> !prescaler_clr)
      else $error("prescaler cleared unasked");

   // unknown words run as no-ops
   none_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && run && op == LBX_OP_NONE |-> !flush ##1 (!reg_wr.en && !zero_we))
      else $error("unknown word had an effect");

   // a frozen core holds its state and its registered outputs; flush is forced low
   ce_freeze_a: assert property (@(posedge clk) disable iff (!resetn)
      !ce |=> acc == $past(acc) && reg_wr == $past(reg_wr)
         && st_r == $past(st_r))
      else $error("state moved while frozen");
endmodule
`default_nettype wire

// [verification/lbx_exec_tb.sv]
// self-checking bench for the logic/bit-op execute block
`default_nettype none
module tb import lbx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // one case: instruction, source byte, port/timer select, expected results
   typedef struct packed {
      logic [11:0] ins;
      logic [7:0] rd;
      logic [1:0] sel;
      logic en;
      logic [7:0] dat;
      logic [2:0] flg;
   } lbx_row_t;
   logic clk = 1'h0;
   logic resetn, ce, instr_valid, rd_is_port, psa_timer, zero_flag, zero_we, flush, prescaler_clr;
   logic [11:0] instr;
   logic [7:0] rd_data, pin_data, acc;
   logic [4:0] rd_addr;
   lbx_wr_t reg_wr;
   int fails = 0;
   int n_tests = 0;
   // sel = {port, timer prescaler}; flg = {zero_we, flush, prescaler_clr}
   lbx_row_t rows [13] = '{
      '{12'h143, 8'h5A, 2'h0, 1'h0, 8'h00, 3'h4}, '{12'h163, 8'h5A, 2'h0, 1'h1, 8'h00, 3'h4},
      '{12'h4E9, 8'hC7, 2'h0, 1'h1, 8'h47, 3'h0}, '{12'h5E9, 8'h0A, 2'h0, 1'h1, 8'h8A, 3'h0},
      '{12'h51F, 8'h00, 2'h0, 1'h1, 8'h01, 3'h0}, '{12'h400, 8'hFF, 2'h0, 1'h1, 8'hFE, 3'h0},
      '{12'h623, 8'h02, 2'h0, 1'h0, 8'h00, 3'h0}, '{12'h623, 8'hFD, 2'h0, 1'h0, 8'h00, 3'h2},
      '{12'h5E9, 8'h00, 2'h0, 1'h0, 8'h00, 3'h0}, '{12'h566, 8'h00, 2'h2, 1'h1, 8'h49, 3'h0},
      '{12'h501, 8'h10, 2'h1, 1'h1, 8'h11, 3'h1}, '{12'h161, 8'h33, 2'h1, 1'h1, 8'h00, 3'h5},
      '{12'h141, 8'h33, 2'h1, 1'h0, 8'h00, 3'h4}};

   lbx_exec dut (.clk(clk), .resetn(resetn), .ce(ce), .instr(instr), .instr_valid(instr_valid),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_is_port(rd_is_port), .pin_data(pin_data),
      .psa_timer(psa_timer), .reg_wr(reg_wr), .acc(acc), .zero_flag(zero_flag),
      .zero_we(zero_we), .flush(flush), .prescaler_clr(prescaler_clr));

   // free-running core clock
   always #5 clk = ~clk;

   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task give_verdict;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // all results cleared while reset is held
   task rst_chk;
      chk({3'h0, zero_flag, zero_we, prescaler_clr, acc}, 14'h0);
      chk({12'h0, reg_wr.en, flush}, 14'h0);
   endtask

   // apply one instruction, check combinational then registered answers
   task automatic step(input lbx_row_t r);
      instr = r.ins;
      rd_data = r.rd;
      rd_is_port = r.sel[1];
      psa_timer = r.sel[0];
      #1;
      chk({9'h0, rd_addr}, {9'h0, r.ins[4:0]});
      chk({13'h0, flush}, {13'h0, r.flg[1]});
      @(posedge clk);
      #1;
      chk({13'h0, reg_wr.en}, {13'h0, r.en});
      if (r.en) chk(reg_wr, {1'h1, r.ins[4:0], r.dat});
      chk({3'h0, zero_flag, zero_we, prescaler_clr, acc}, {4'h1, r.flg[2], r.flg[0], 8'h00});
   endtask

   // watchdog against a hung run
   initial begin
      #2000;
      fails++;
      give_verdict();
   end

   // main sequence
   initial begin
      resetn = 1'h0;
      ce = 1'h1;
      instr_valid = 1'h1;
      instr = 12'h000;
      rd_data = 8'h00;
      pin_data = 8'h41;
      rd_is_port = 1'h0;
      psa_timer = 1'h0;
      repeat (16) @(posedge clk);
      #1;
      rst_chk();
      resetn = 1'h1;
      foreach (rows[i]) step(rows[i]);
      // clock enable low: a bit set must not land
      ce = 1'h0;
      instr = 12'h623;
      rd_data = 8'hFD;
      #1;
      chk({13'h0, flush}, 14'h0);
      instr = 12'h5E9;
      @(posedge clk);
      #1;
      chk({13'h0, reg_wr.en}, 14'h0);
      ce = 1'h1;
      // reset in mid-run returns everything to idle
      resetn = 1'h0;
      instr = 12'h000;
      #1;
      rst_chk();
      @(posedge clk);
      #1;
      resetn = 1'h1;
      give_verdict();
   end
endmodule
`default_nettype wire
